// [hdl/eeprom_loader_defines.vh]
// Purpose: Shared constants of the serial NVM configuration loader
// Assumes: Included by bare name from every design file but the FIFO
// Notes:   Definitions only
`ifndef EEPROM_LOADER_DEFINES_VH
`define EEPROM_LOADER_DEFINES_VH

// Image layout, in 16-bit word addresses
`define SIGNATURE      16'h1516
`define SIG_WORD       8'h00
`define LINK_WORD      8'h10
`define PM_WORD        8'h28
`define TCVC_WORD      8'h30
`define CFG_DEFAULT    16'h0000

// Memory opcodes and frame lengths
`define OP_READ        8'h03
`define OP_WRITE       8'h02
`define OP_WREN        8'h06
`define PAD_WORD       16'h0000
`define PAD_WREN       24'h000000
`define FRAME_BITS     6'd32
`define WREN_BITS      6'd8

// Register byte addresses
`define STATUS_ADDR    12'h0a0
`define SEQ_CTRL_ADDR  12'h0a4
`define SEQ_DATA_ADDR  12'h0a8
`define IMAGE_SEL      3'h1
`define SEL_MSB        11
`define SEL_LSB        9
`define IDX_MSB        8
`define IDX_LSB        2

// Field positions
`define BUSY_BIT       0
`define SIGOK_BIT      1
`define LOADING_BIT    2
`define DONE_BIT       4
`define START_BIT      0
`define WRCMD_BIT      1
`define ADDR_MSB       15
`define ADDR_LSB       8
`define DATA_MSB       15
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

`endif

// [hdl/word_fifo.v]
// Purpose: Synchronous FIFO between the serial reader and register writes
// Assumes: One clock, synchronous active-low reset
// Notes:   DEPTH must be a power of two; AW is its log2
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
   parameter WIDTH = 24,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   // Clock and reset
   input  wire             aclk,
   input  wire             aresetn,
   // Fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wr_ptr_reg;
   reg [AW:0]      rd_ptr_reg;

   wire full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   wire empty = (wr_ptr_reg == rd_ptr_reg);

   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[rd_ptr_reg[AW-1:0]];

   always @(posedge aclk)
   begin
      if (in_valid && !full)
         mem[wr_ptr_reg[AW-1:0]] <= in_data;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_ptr_reg <= {(AW+1){1'b0}};
         rd_ptr_reg <= {(AW+1){1'b0}};
      end
      else
      begin
         if (in_valid && !full)
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (out_ready && !empty)
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
   end

endmodule
`default_nettype wire

// [hdl/spi_word_engine.v]
// Purpose: SPI mode 0 master moving one frame of up to 32 bits
// Assumes: Serial input is asynchronous and is synchronised here
// Notes:   HALF_DIV of at least 4 leaves room for the two-flop delay
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_loader_defines.vh"

module spi_word_engine #(
   parameter HALF_DIV = 4
) (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // Frame request
   input  wire        start,
   input  wire [5:0]  nbits,
   input  wire [31:0] tx,
   output wire        busy,
   output reg         done_reg,
   output reg  [15:0] rx_reg,
   // Memory pins
   output reg         sck_reg,
   output reg         cs_n_reg,
   output reg         mosi_reg,
   input  wire        miso
);

   localparam E_IDLE = 4'b0001;
   localparam E_LOW  = 4'b0010;
   localparam E_HIGH = 4'b0100;
   localparam E_GAP  = 4'b1000;

   reg [3:0]  state_reg;
   reg [7:0]  div_reg;
   reg [5:0]  bits_reg;
   reg [31:0] shift_reg;
   reg        miso_meta_reg;
   reg        miso_s_reg;

   wire tick = (div_reg == HALF_DIV[7:0] - 8'h01);

   assign busy = !state_reg[0];

   always @(posedge aclk)
   begin
      miso_meta_reg <= miso;
      miso_s_reg    <= miso_meta_reg;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= E_IDLE;
         div_reg   <= 8'h00;
         bits_reg  <= 6'h00;
         shift_reg <= 32'h00000000;
         rx_reg    <= 16'h0000;
         done_reg  <= 1'b0;
         sck_reg   <= 1'b0;
         cs_n_reg  <= 1'b1;
         mosi_reg  <= 1'b0;
      end
      else
      begin
         done_reg <= 1'b0;
         div_reg  <= (tick || state_reg[0]) ? 8'h00 : div_reg + 8'h01;
         case (state_reg)
            E_IDLE:
               if (start)
               begin
                  cs_n_reg  <= 1'b0;
                  shift_reg <= tx;
                  bits_reg  <= nbits;
                  mosi_reg  <= tx[31];
                  state_reg <= E_LOW;
               end
            E_LOW:
               if (tick)
               begin
                  // Sampled at the rising edge we drive
                  sck_reg   <= 1'b1;
                  rx_reg    <= {rx_reg[14:0], miso_s_reg};
                  state_reg <= E_HIGH;
               end
            E_HIGH:
               if (tick)
               begin
                  sck_reg  <= 1'b0;
                  bits_reg <= bits_reg - 6'h01;
                  if (bits_reg == 6'h01)
                     state_reg <= E_GAP;
                  else
                  begin
                     shift_reg <= {shift_reg[30:0], 1'b0};
                     mosi_reg  <= shift_reg[30];
                     state_reg <= E_LOW;
                  end
               end
            E_GAP:
               if (tick)
               begin
                  // Select stays high for a full half period
                  if (!cs_n_reg)
                     cs_n_reg <= 1'b1;
                  else
                  begin
                     done_reg  <= 1'b1;
                     state_reg <= E_IDLE;
                  end
               end
            default:
               state_reg <= E_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

// [hdl/nvm_config_loader.v]
// Purpose: Serial NVM configuration loader with a single-word sequencer
// Assumes: aclk 20 MHz; AXI4-Lite slave; SPI mode 0 memory
// Notes:   One read in flight; the FIFO absorbs register-write stalls
//
// Operation
// - Four pins drive the memory: clock, select, data out, data in.
// - Loading begins once fundamental reset is released, before host access.
// - Memory holds 16-bit words, each addressed by an 8-bit word address.
// - Software starts single-word reads or writes via start, address, command.
// - First word is read and compared with the signature before loading.
// - Loading reads consecutive words, each into its assigned register.
// - Bit 4 of the status register at A0h shows load complete.
// - Words at 20h to 2Ah give link and deskew setup, ports 0-5.
// - Words from 50h give each port power-management capability and data.
// - Words from 60h give each port TC map, slot and port number.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_loader_defines.vh"

module nvm_config_loader #(
   parameter       HALF_DIV   = 4,
   parameter       FIFO_DEPTH = 8,
   parameter       FIFO_AW    = 3,
   parameter       PORTS      = 6,
   parameter [7:0] LAST_WORD  = 8'h7f
) (
   // Clock and reset
   input  wire                  aclk,
   input  wire                  aresetn,
   input  wire                  fundamental_reset_n,
   // AXI4-Lite write
   input  wire [11:0]           awaddr,
   input  wire                  awvalid,
   output wire                  awready,
   input  wire [31:0]           wdata,
   input  wire [3:0]            wstrb,
   input  wire                  wvalid,
   output wire                  wready,
   output reg  [1:0]            bresp,
   output reg                   bvalid,
   input  wire                  bready,
   // AXI4-Lite read
   input  wire [11:0]           araddr,
   input  wire                  arvalid,
   output wire                  arready,
   output reg  [31:0]           rdata,
   output reg  [1:0]            rresp,
   output reg                   rvalid,
   input  wire                  rready,
   // Memory pins
   output wire                  nvm_serial_clock,
   output wire                  nvm_select_n,
   output wire                  nvm_serial_out,
   input  wire                  nvm_serial_in,
   // Loaded configuration
   output wire                  load_complete,
   output wire [PORTS*16-1:0]   port_link_cfg,
   output wire [PORTS*16-1:0]   port_pm_cfg,
   output wire [PORTS*16-1:0]   port_tcvc_cfg
);

   localparam S_IDLE  = 7'b0000001;
   localparam S_SIG   = 7'b0000010;
   localparam S_LOAD  = 7'b0000100;
   localparam S_FLUSH = 7'b0001000;
   localparam S_READY = 7'b0010000;
   localparam S_WREN  = 7'b0100000;
   localparam S_XFER  = 7'b1000000;

   reg [15:0] image [0:127];

   reg        perst_meta_reg;
   reg        perst_s_reg;
   reg [6:0]  state_reg;
   reg [7:0]  word_addr_reg;
   reg        pend_reg;
   reg        done_reg;
   reg        sig_ok_reg;
   reg        seq_busy_reg;
   reg        seq_wr_reg;
   reg [7:0]  seq_addr_reg;
   reg [15:0] seq_data_reg;
   reg        spi_start_reg;
   reg [31:0] spi_tx_reg;
   reg [5:0]  spi_bits_reg;
   reg        aw_held_reg;
   reg        w_held_reg;
   reg [11:0] aw_addr_reg;
   reg [31:0] wdata_reg;
   reg [3:0]  wstrb_reg;
   reg [31:0] rd_word;
   reg [1:0]  rd_resp;
   reg [31:0] status_word;

   wire        spi_busy;
   wire        spi_done;
   wire [15:0] spi_rx;
   wire        fifo_in_ready;
   wire        fifo_out_valid;
   wire [23:0] fifo_out_data;

   function [15:0] merge16;
      input [15:0] old_v;
      input [15:0] new_v;
      input [1:0]  strb;
      begin
         merge16 = {strb[1] ? new_v[15:8] : old_v[15:8],
                    strb[0] ? new_v[7:0]  : old_v[7:0]};
      end
   endfunction

   // Register write decode
   wire wr_fire   = aw_held_reg && w_held_reg && !bvalid;
   wire wsel_stat = (aw_addr_reg == `STATUS_ADDR);
   wire wsel_ctrl = (aw_addr_reg == `SEQ_CTRL_ADDR);
   wire wsel_data = (aw_addr_reg == `SEQ_DATA_ADDR);
   wire wsel_img  = (aw_addr_reg[`SEL_MSB:`SEL_LSB] == `IMAGE_SEL);
   wire wr_known  = wsel_stat || wsel_ctrl || wsel_data || wsel_img;
   wire seq_go    = wr_fire && wsel_ctrl && wstrb_reg[0] &&
                    wdata_reg[`START_BIT];
   wire [7:0] seq_addr_new = wstrb_reg[1] ?
                             wdata_reg[`ADDR_MSB:`ADDR_LSB] : seq_addr_reg;
   wire       seq_wr_new   = wdata_reg[`WRCMD_BIT];

   // Image writes from software take the single write port first
   wire       drain_ready = !(wr_fire && wsel_img);
   wire       drain_fire  = fifo_out_valid && drain_ready;
   wire [7:0] drain_addr  = fifo_out_data[23:16];
   wire       fifo_push   = spi_done && (state_reg == S_SIG ||
                                         state_reg == S_LOAD);

   assign awready       = !aw_held_reg;
   assign wready        = !w_held_reg;
   assign arready       = !rvalid;
   assign load_complete = done_reg;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         perst_meta_reg <= 1'b0;
         perst_s_reg    <= 1'b0;
      end
      else
      begin
         perst_meta_reg <= fundamental_reset_n;
         perst_s_reg    <= perst_meta_reg;
      end
   end

   spi_word_engine #(
      .HALF_DIV (HALF_DIV)
   ) u_spi (
      .aclk     (aclk),
      // Fundamental reset aborts a frame in flight, so no stale done
      .aresetn  (aresetn && perst_s_reg),
      .start    (spi_start_reg),
      .nbits    (spi_bits_reg),
      .tx       (spi_tx_reg),
      .busy     (spi_busy),
      .done_reg (spi_done),
      .rx_reg   (spi_rx),
      .sck_reg  (nvm_serial_clock),
      .cs_n_reg (nvm_select_n),
      .mosi_reg (nvm_serial_out),
      .miso     (nvm_serial_in)
   );

   word_fifo #(
      .WIDTH (24),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_valid  (fifo_push),
      .in_ready  (fifo_in_ready),
      .in_data   ({word_addr_reg, spi_rx}),
      .out_valid (fifo_out_valid),
      .out_ready (drain_ready),
      .out_data  (fifo_out_data)
   );

   // AXI4-Lite write channels and response
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         aw_addr_reg <= 12'h000;
         wdata_reg   <= 32'h00000000;
         wstrb_reg   <= 4'h0;
         bvalid      <= 1'b0;
         bresp       <= `RESP_OKAY;
      end
      else
      begin
         if (awvalid && !aw_held_reg)
         begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= awaddr;
         end
         else if (wr_fire)
            aw_held_reg <= 1'b0;
         if (wvalid && !w_held_reg)
         begin
            w_held_reg <= 1'b1;
            wdata_reg  <= wdata;
            wstrb_reg  <= wstrb;
         end
         else if (wr_fire)
            w_held_reg <= 1'b0;
         if (wr_fire)
         begin
            bvalid <= 1'b1;
            bresp  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (bready)
            bvalid <= 1'b0;
      end
   end

   // Read decode
   always @*
   begin
      status_word = 32'h00000000;
      status_word[`BUSY_BIT]    = seq_busy_reg;
      status_word[`SIGOK_BIT]   = sig_ok_reg;
      status_word[`LOADING_BIT] = state_reg[1] || state_reg[2] ||
                                  state_reg[3];
      status_word[`DONE_BIT]    = done_reg;
      rd_word = 32'h00000000;
      rd_resp = `RESP_OKAY;
      if (araddr == `STATUS_ADDR)
         rd_word = status_word;
      else if (araddr == `SEQ_CTRL_ADDR)
      begin
         rd_word[`ADDR_MSB:`ADDR_LSB] = seq_addr_reg;
         rd_word[`WRCMD_BIT]          = seq_wr_reg;
      end
      else if (araddr == `SEQ_DATA_ADDR)
         rd_word[`DATA_MSB:0] = seq_data_reg;
      else if (araddr[`SEL_MSB:`SEL_LSB] == `IMAGE_SEL)
         rd_word[`DATA_MSB:0] = image[araddr[`IDX_MSB:`IDX_LSB]];
      else
         rd_resp = `RESP_SLVERR;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rdata  <= 32'h00000000;
         rresp  <= `RESP_OKAY;
      end
      else if (arvalid && !rvalid)
      begin
         rvalid <= 1'b1;
         rdata  <= rd_word;
         rresp  <= rd_resp;
      end
      else if (rready)
         rvalid <= 1'b0;
   end

   // Image store: one write port shared by software and the loader
   always @(posedge aclk)
   begin
      if (wr_fire && wsel_img)
         image[aw_addr_reg[`IDX_MSB:`IDX_LSB]] <=
            merge16(image[aw_addr_reg[`IDX_MSB:`IDX_LSB]],
                    wdata_reg[`DATA_MSB:0], wstrb_reg[1:0]);
      else if (drain_fire)
         image[drain_addr[6:0]] <= fifo_out_data[15:0];
   end

   // Per-port configuration captured as the words drain
   genvar p;
   generate
      for (p = 0; p < PORTS; p = p + 1)
      begin : g_port
         localparam [7:0] PI = p;
         reg [15:0] link_reg;
         reg [15:0] pm_reg;
         reg [15:0] tcvc_reg;
         always @(posedge aclk)
         begin
            // Fundamental reset restores the hardware defaults
            if (!aresetn || !perst_s_reg)
            begin
               link_reg <= `CFG_DEFAULT;
               pm_reg   <= `CFG_DEFAULT;
               tcvc_reg <= `CFG_DEFAULT;
            end
            else if (drain_fire)
            begin
               if (drain_addr == `LINK_WORD + PI)
                  link_reg <= fifo_out_data[15:0];
               if (drain_addr == `PM_WORD + PI)
                  pm_reg <= fifo_out_data[15:0];
               if (drain_addr == `TCVC_WORD + PI)
                  tcvc_reg <= fifo_out_data[15:0];
            end
         end
         assign port_link_cfg[p*16 +: 16] = link_reg;
         assign port_pm_cfg[p*16 +: 16]   = pm_reg;
         assign port_tcvc_cfg[p*16 +: 16] = tcvc_reg;
      end
   endgenerate

   // Loader and sequencer control
   always @(posedge aclk)
   begin
      if (!aresetn || !perst_s_reg)
      begin
         state_reg     <= S_IDLE;
         word_addr_reg <= `SIG_WORD;
         pend_reg      <= 1'b0;
         done_reg      <= 1'b0;
         sig_ok_reg    <= 1'b0;
         seq_busy_reg  <= 1'b0;
         seq_wr_reg    <= 1'b0;
         seq_addr_reg  <= 8'h00;
         seq_data_reg  <= 16'h0000;
         spi_start_reg <= 1'b0;
         spi_tx_reg    <= 32'h00000000;
         spi_bits_reg  <= 6'h00;
      end
      else
      begin
         spi_start_reg <= 1'b0;
         if (wr_fire && wsel_ctrl && wstrb_reg[1])
            seq_addr_reg <= wdata_reg[`ADDR_MSB:`ADDR_LSB];
         if (wr_fire && wsel_ctrl && wstrb_reg[0])
            seq_wr_reg <= seq_wr_new;
         if (wr_fire && wsel_data)
            seq_data_reg <= merge16(seq_data_reg, wdata_reg[`DATA_MSB:0],
                                    wstrb_reg[1:0]);
         case (state_reg)
            S_IDLE:
            begin
               // Reached only with fundamental reset released
               spi_tx_reg    <= {`OP_READ, `SIG_WORD, `PAD_WORD};
               spi_bits_reg  <= `FRAME_BITS;
               spi_start_reg <= 1'b1;
               pend_reg      <= 1'b1;
               word_addr_reg <= `SIG_WORD;
               state_reg     <= S_SIG;
            end
            S_SIG:
               if (spi_done)
               begin
                  pend_reg <= 1'b0;
                  if (spi_rx == `SIGNATURE)
                  begin
                     sig_ok_reg    <= 1'b1;
                     word_addr_reg <= word_addr_reg + 8'h01;
                     state_reg     <= S_LOAD;
                  end
                  else
                     state_reg <= S_FLUSH;
               end
            S_LOAD:
               if (spi_done)
               begin
                  pend_reg <= 1'b0;
                  if (word_addr_reg == LAST_WORD)
                     state_reg <= S_FLUSH;
                  else
                     word_addr_reg <= word_addr_reg + 8'h01;
               end
               else if (!pend_reg && fifo_in_ready)
               begin
                  // Space is checked first so the push is never refused
                  spi_tx_reg    <= {`OP_READ, word_addr_reg, `PAD_WORD};
                  spi_bits_reg  <= `FRAME_BITS;
                  spi_start_reg <= 1'b1;
                  pend_reg      <= 1'b1;
               end
            S_FLUSH:
               if (!fifo_out_valid)
               begin
                  done_reg  <= 1'b1;
                  state_reg <= S_READY;
               end
            S_READY:
               // Starts during a busy access are never seen here
               if (seq_go)
               begin
                  seq_busy_reg  <= 1'b1;
                  seq_addr_reg  <= seq_addr_new;
                  spi_start_reg <= 1'b1;
                  if (seq_wr_new)
                  begin
                     spi_tx_reg   <= {`OP_WREN, `PAD_WREN};
                     spi_bits_reg <= `WREN_BITS;
                     state_reg    <= S_WREN;
                  end
                  else
                  begin
                     spi_tx_reg   <= {`OP_READ, seq_addr_new, `PAD_WORD};
                     spi_bits_reg <= `FRAME_BITS;
                     state_reg    <= S_XFER;
                  end
               end
            S_WREN:
               if (spi_done)
               begin
                  spi_tx_reg    <= {`OP_WRITE, seq_addr_reg, seq_data_reg};
                  spi_bits_reg  <= `FRAME_BITS;
                  spi_start_reg <= 1'b1;
                  state_reg     <= S_XFER;
               end
            S_XFER:
               if (spi_done)
               begin
                  if (!seq_wr_reg)
                     seq_data_reg <= spi_rx;
                  seq_busy_reg <= 1'b0;
                  state_reg    <= S_READY;
               end
            default:
               state_reg <= S_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

// [dv/loader_chk_sva.sv]
// Purpose: Assertions on the loader ports
// Assumes: HALF_DIV of 4; the gap check is written for it
// Notes:   Select-low time is counted in helper logic
`timescale 1ns/1ps
`default_nettype none
module loader_chk #(
   parameter HALF_DIV = 4
) (
   // Clock, resets and bus handshakes
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic fundamental_reset_n,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic bvalid,
   input wire logic bready,
   // Memory pins and status
   input wire logic nvm_serial_clock,
   input wire logic nvm_select_n,
   input wire logic nvm_serial_out,
   input wire logic load_complete
);
   logic [9:0] low_reg;
   always_ff @(posedge aclk)
      low_reg <= (!aresetn || nvm_select_n) ? 10'h000 : low_reg + 10'h001;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_idle_clk: assert property (nvm_select_n |-> !nvm_serial_clock)
      else $error("clock high while deselected");
   chk_out_hold:
      assert property (!nvm_select_n && nvm_serial_clock
         |-> $stable(nvm_serial_out)) else $error("data moved in high phase");
   chk_frame_len:
      assert property ($rose(nvm_select_n) |-> low_reg == 65 * HALF_DIV
         || low_reg == 17 * HALF_DIV) else $error("bad frame length");
   chk_select_gap:
      assert property ($rose(nvm_select_n) |-> nvm_select_n [*4])
      else $error("select high too briefly");
   // Six cycles leave room for the two-flop pin synchroniser
   chk_pin_reset:
      assert property (!fundamental_reset_n [*6]
         |-> nvm_select_n && !load_complete) else $error("active in reset");
   chk_done_keep:
      assert property (load_complete && fundamental_reset_n |=> load_complete)
      else $error("load complete dropped");
   chk_read_latency:
      assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read answer late");
   chk_write_hold:
      assert property (bvalid |=> bvalid == !$past(bready))
      else $error("write answer not held to its handshake");
   cover property ($rose(load_complete));
   cover property ($rose(nvm_select_n) && low_reg == 17 * HALF_DIV);
   cover property (bvalid && bready);
endmodule
bind nvm_config_loader loader_chk #(.HALF_DIV(HALF_DIV)) u_loader_chk (.*);
`default_nettype wire

// [dv/spi_mem_model.sv]
// Purpose: Serial memory on the far side of the loader
// Assumes: Mode 0 framing, opcode 03h reads and 02h writes
// Notes:   Write-enable frames are taken and ignored
`timescale 1ns/1ps
`default_nettype none
module spi_mem_model (
   // Memory pins
   input  wire logic sck,
   input  wire logic cs_n,
   input  wire logic mosi,
   output var  logic miso
);
   logic [15:0] mem [0:255];
   logic [31:0] sh;
   logic [15:0] word;
   logic        rd = 1'b0;
   logic        slow = 1'b0;
   int          cnt = 0;
   initial
      miso = 1'b0;
   always @(negedge cs_n)
   begin
      cnt = 0;
      rd = 1'b0;
   end
   // No pull on the line, so a released line flips
   always @(posedge cs_n)
      miso <= ~miso;
   always @(posedge sck)
   begin
      sh = {sh[30:0], mosi};
      cnt = cnt + 1;
      if (cnt == 16)
      begin
         rd = sh[15:8] == 8'h03;
         word = mem[sh[7:0]];
      end
      if (cnt == 32 && sh[31:24] == 8'h02)
         mem[sh[23:16]] = sh[15:0];
   end
   // Slow mode leaves only 20 ns of setup before sampling
   always @(negedge sck)
      miso <= #(slow ? 80 : 5) (rd && cnt < 32) ? word[31-cnt] : ~miso;
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Purpose: Self-checking bench of the NVM config loader
// Assumes: Image preset in the memory model before reset
// Notes:   LAST_WORD lowered to keep the load short
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_loader_defines.vh"
module tb_top;
   logic        aclk, aresetn, fundamental_reset_n, awvalid, awready;
   logic        wvalid, wready, bvalid, bready, arvalid, arready, rvalid;
   logic        rready, load_complete, nvm_serial_in, nvm_serial_out;
   logic        nvm_serial_clock, nvm_select_n;
   logic [1:0]  bresp, rresp, rs;
   logic [3:0]  wstrb;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [95:0] port_link_cfg, port_pm_cfg, port_tcvc_cfg;
   int          miscompares, checked, i;
   nvm_config_loader #(.LAST_WORD(8'h35)) u_nvm_config_loader (.*);
   spi_mem_model u_spi_mem_model (.sck(nvm_serial_clock),
      .cs_n(nvm_select_n), .mosi(nvm_serial_out), .miso(nvm_serial_in));
   initial
   begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   function automatic logic [15:0] img(input logic [7:0] a);
      return {a ^ 8'h5a, a};
   endfunction
   task automatic check(input string n, input logic [47:0] s, e);
      checked++;
      if (s !== e)
         $display("mismatch %s expected %h seen %h", n, e, s);
      miscompares += (s !== e);
   endtask
   task automatic results;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Ready and answer are read at the falling edge, before the next rise
   task automatic axi(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      logic ta, tw, tv;
      @(posedge aclk);
      {awaddr, araddr, wdata} <= {a, a, d};
      {awvalid, wvalid, bready} <= {3{w}};
      {arvalid, rready} <= {2{~w}};
      forever
      begin
         @(negedge aclk);
         {ta, tw, tv} = w ? {awready, wready, bvalid} : {arready, 1'b0, rvalid};
         {rd, rs} = w ? {rd, bresp} : {rdata, rresp};
         @(posedge aclk);
         {awvalid, arvalid} <= {awvalid, arvalid} & ~{2{ta}};
         wvalid <= wvalid & ~tw;
         if (tv)
            break;
      end
      {bready, rready} <= 2'b00;
   endtask
   // Only the watchdog ends a poll that never sees its value
   task automatic poll(input int b, input logic v);
      do
         axi(1'b0, `STATUS_ADDR, 32'h0);
      while (rd[b] !== v);
   endtask
   initial
   begin
      {aresetn, fundamental_reset_n, awvalid, wvalid, bready} = 5'h00;
      {arvalid, rready, awaddr, araddr, wdata, wstrb} = 62'hf;
      for (i = 0; i < 256; i++)
         u_spi_mem_model.mem[i] = img(i[7:0]);
      u_spi_mem_model.mem[0] = `SIGNATURE;
      repeat (6) @(posedge aclk);
      {aresetn, fundamental_reset_n} <= 2'b11;
      axi(1'b0, `STATUS_ADDR, 32'h0);
      check("early done", rd[`DONE_BIT], 1'b0);
      poll(`DONE_BIT, 1'b1);
      check("status", {load_complete, rd}, {1'b1, 32'h12});
      for (i = 0; i < 6; i++)
         check("cfg", {port_link_cfg[16*i+:16],
            port_pm_cfg[16*i+:16], port_tcvc_cfg[16*i+:16]},
            {img(8'h10 + i[7:0]), img(8'h28 + i[7:0]), img(8'h30 + i[7:0])});
      axi(1'b0, 12'h2d4, 32'h0);
      check("image", rd, {16'h0, img(8'h35)});
      wstrb <= 4'h1;
      axi(1'b1, 12'h2d4, 32'hffc3);
      wstrb <= 4'hf;
      axi(1'b0, 12'h2d4, 32'h0);
      check("image write", rd, {16'h0, 8'h35 ^ 8'h5a, 8'hc3});
      axi(1'b0, 12'h100, 32'h0);
      check("unmapped", {rs, rd[15:0]}, {`RESP_SLVERR, 16'h0});
      axi(1'b1, 12'h100, 32'h0);
      check("unmapped write", rs, `RESP_SLVERR);
      u_spi_mem_model.slow = 1'b1;
      axi(1'b1, `SEQ_CTRL_ADDR, 32'h7701);
      check("bresp", rs, `RESP_OKAY);
      poll(`BUSY_BIT, 1'b0);
      axi(1'b0, `SEQ_DATA_ADDR, 32'h0);
      check("seq read", rd, {16'h0, img(8'h77)});
      axi(1'b1, `SEQ_DATA_ADDR, 32'hbeef);
      axi(1'b1, `SEQ_CTRL_ADDR, 32'h4003);
      poll(`BUSY_BIT, 1'b0);
      check("seq write", u_spi_mem_model.mem[8'h40], 32'hbeef);
      u_spi_mem_model.mem[0] = 16'h1517;
      fundamental_reset_n <= 1'b0;
      repeat (8) @(posedge aclk);
      fundamental_reset_n <= 1'b1;
      poll(`DONE_BIT, 1'b1);
      check("bad sig", {rd[15:0], port_link_cfg[15:0]},
         {16'h10, `CFG_DEFAULT});
      results;
   end
   // Two loads take about 15k cycles; this leaves over twice that
   initial
   begin
      repeat (40000) @(posedge aclk);
      miscompares++;
      results;
   end
endmodule
`default_nettype wire
